/* fms_pkg.sv */
// Package of constants and carrier types for the mode select and supervision block
package fms_pkg;

	// ------------------------------------------------------------
	// Register map (word-indexed byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_ROT_SEL   = 8'h04;
	localparam logic [7:0] ADDR_ISMAX     = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0c;
	localparam logic [7:0] ADDR_TSCLK     = 8'h10;
	localparam logic [7:0] ADDR_OVI_LIMIT = 8'h14;
	localparam logic [7:0] ADDR_CONFIG    = 8'h18;

	// ------------------------------------------------------------
	// Control register field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODTYPE_REQ = 0;
	localparam int CTRL_THREE_PHASE = 1;
	localparam int CTRL_SPEED_TO_TORQUE = 2;
	localparam int CTRL_MANROT_TO_SPEED = 3;
	localparam int CTRL_FBK_ANGDEF  = 4;
	localparam int CTRL_OBS_RESET   = 5;
	localparam int CTRL_OBS_VSACT   = 6;
	localparam int CTRL_OVI_CLEAR   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Status register field positions
	localparam int STAT_MODTYPE  = 0;
	localparam int STAT_ISOVER   = 1;
	localparam int STAT_OVI_LO   = 2;
	localparam int STAT_FWDIR    = 6;
	localparam int STAT_MOVING   = 7;
	localparam int STAT_MODE_LO  = 8;

	// ------------------------------------------------------------
	// Build-time configuration defaults
	// ------------------------------------------------------------
	localparam logic [11:0] IN_ENABLE_MAP_DEF = 12'h083;
	localparam logic [11:0] IN_INVERT_MAP_DEF = 12'h000;
	localparam logic [1:0]  NPHS_DEF          = 2'h3;
	localparam logic [1:0]  EXC_POL_DEF       = 2'h0;
	localparam logic [1:0]  ANG_LUT_DEF       = 2'h0;
	localparam logic [1:0]  MANROT_DEF        = 2'h2;
	localparam logic [3:0]  OVF_CLIM_DEF      = 4'h1;
	localparam int          IPHS_CHANNELS     = 3;

	// Modulator type encoding
	typedef enum logic {
		MOD_PWM  = 1'b0,
		MOD_RPFM = 1'b1
	} fms_mod_type;

	// Control mode, one-hot
	typedef enum logic [2:0] {
		MODE_TORQUE  = 3'b001,
		MODE_SPD_DIR = 3'b010,
		MODE_SPD_MRT = 3'b100
	} fms_mode_type;

	// Rotor angle source selector codes
	localparam logic [3:0] ROT_ENCODER  = 4'h0;
	localparam logic [3:0] ROT_HALL     = 4'h1;
	localparam logic [3:0] ROT_RESOLV0  = 4'h2;
	localparam logic [3:0] ROT_RESOLV1  = 4'h3;
	localparam logic [3:0] ROT_OBSERVER = 4'h4;
	localparam logic [3:0] ROT_MANROT   = 4'h5;
	localparam logic [3:0] ROT_EXT0     = 4'h6;
	localparam logic [3:0] ROT_EXT1     = 4'h7;

	// Angle sources travelling together
	typedef struct packed {
		logic [31:0] encoder;
		logic [31:0] hall;
		logic [31:0] resolv0;
		logic [31:0] resolv1;
		logic [31:0] observer;
		logic [31:0] manrot;
		logic [31:0] ext0;
		logic [31:0] ext1;
	} fms_angles_type;

	// Modulator coil drive patterns
	typedef struct packed {
		logic [5:0] pwm;
		logic [5:0] pfm;
	} fms_coil_type;

endpackage

/* fms_top.sv */
// Modulator select, overcurrent supervision, mode and angle selection
`timescale 1ns/10ps
module fms_top #(
	parameter logic [3:0]  overcurrent_consecutive_limit = fms_pkg::OVF_CLIM_DEF,
	parameter logic [11:0] input_channel_enable_map = fms_pkg::IN_ENABLE_MAP_DEF,
	parameter logic [11:0] input_channel_invert_map = fms_pkg::IN_INVERT_MAP_DEF,
	parameter logic [1:0]  transform_input_phase_count = fms_pkg::NPHS_DEF,
	parameter logic [1:0]  exciter_polarity_param    = fms_pkg::EXC_POL_DEF,
	parameter logic [1:0]  angle_table_size_param    = fms_pkg::ANG_LUT_DEF,
	parameter logic [1:0]  manrot_option_param       = fms_pkg::MANROT_DEF,
	parameter bit          phase_overcurrent_enable  = 1'b1,
	parameter bit          link_overcurrent_enable   = 1'b1
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic [31:0]                 reg_rdata,
	input  wire logic                   cycle_sync,
	input  wire logic [16:0]            is_modulus,
	input  wire logic [16:0]            iphs_a_mag,
	input  wire logic [16:0]            iphs_b_mag,
	input  wire logic [16:0]            iphs_c_mag,
	input  wire logic [16:0]            ibus_mag,
	input  wire fms_pkg::fms_coil_type  coil_in,
	input  wire fms_pkg::fms_angles_type angles_in,
	input  wire logic [31:0]            preset_angle,
	input  wire logic                   eval_fwdir,
	input  wire logic                   eval_moving,
	input  wire logic [31:0]            position_in,
	output logic [5:0]                  coil_drive,
	output logic                        modtype_ack,
	output logic                        ismodover,
	output logic [3:0]                  ovi_flags,
	output logic [2:0]                  ctrl_mode,
	output logic [31:0]                 rot_angle,
	output logic [31:0]                 fbk_angle,
	output logic [11:0]                 tsclocks,
	output logic                        spd_fwdir,
	output logic                        spd_moving,
	output logic                        obs_reset,
	output logic                        obs_use_measured,
	output logic [31:0]                 pos_position
);

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------

	// Frequency modulation only legal on a three-phase motor
	function automatic logic mod_ack(input logic req, input logic three);
		mod_ack = req & three;
	endfunction

	// Mode matrix: speed-to-torque low wins over the other bit
	function automatic fms_pkg::fms_mode_type mode_dec(input logic s2t,
		input logic m2s);
		if (!s2t) begin
			mode_dec = fms_pkg::MODE_TORQUE;
		end else if (!m2s) begin
			mode_dec = fms_pkg::MODE_SPD_DIR;
		end else begin
			mode_dec = fms_pkg::MODE_SPD_MRT;
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]  ctrl_reg;
	logic [3:0]  rot_sel_reg;
	logic [16:0] ismax_reg;
	logic [16:0] iphs_limit_reg;
	logic [16:0] ibus_limit_reg;
	logic [3:0]  ovf_cnt_reg;
	logic [11:0] ts_cnt_reg;
	logic [31:0] rot_next;
	logic [3:0]  ovi_hit;
	logic        ack_next;

	assign ack_next = mod_ack(ctrl_reg[fms_pkg::CTRL_MODTYPE_REQ],
		ctrl_reg[fms_pkg::CTRL_THREE_PHASE]);

	// Host writes; overcurrent clear bit is a self-clearing strobe
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg       <= fms_pkg::CTRL_RESET;
			rot_sel_reg    <= 4'h0;
			ismax_reg      <= 17'h1ffff;
			iphs_limit_reg <= 17'h1ffff;
			ibus_limit_reg <= 17'h1ffff;
		end else begin
			ctrl_reg[fms_pkg::CTRL_OVI_CLEAR] <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
					fms_pkg::ADDR_CTRL: begin
						ctrl_reg <= reg_wdata[7:0];
					end
					fms_pkg::ADDR_ROT_SEL: begin
						rot_sel_reg <= reg_wdata[3:0];
					end
					fms_pkg::ADDR_ISMAX: begin
						ismax_reg <= reg_wdata[16:0];
					end
					fms_pkg::ADDR_OVI_LIMIT: begin
						iphs_limit_reg <= reg_wdata[16:0];
					end
					fms_pkg::ADDR_CONFIG: begin
						ibus_limit_reg <= reg_wdata[16:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Modulator selection and coil drive
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			modtype_ack <= fms_pkg::MOD_PWM;
			coil_drive  <= 6'h00;
		end else begin
			modtype_ack <= ack_next;
			coil_drive  <= ack_next ? coil_in.pfm : coil_in.pwm;
		end
	end

	// ------------------------------------------------------------
	// Current magnitude overflow, judged once per control cycle
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovf_cnt_reg <= 4'h0;
			ismodover   <= 1'b0;
		end else if (cycle_sync) begin
			if (is_modulus > ismax_reg) begin
				if (ovf_cnt_reg < overcurrent_consecutive_limit) begin
					ovf_cnt_reg <= ovf_cnt_reg + 4'h1;
				end
				// Flag follows the count, so it drops on a good cycle;
				// one extra bit keeps a limit of 15 from wrapping to zero
				ismodover <= ({1'b0, ovf_cnt_reg} + 5'h01 >=
					{1'b0, overcurrent_consecutive_limit});
			end else begin
				ovf_cnt_reg <= 4'h0;
				ismodover   <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Per-channel overcurrent, sticky until host clear
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < fms_pkg::IPHS_CHANNELS; g++) begin : g_phs
			logic [16:0] mag;
			assign mag = (g == 0) ? iphs_a_mag :
				(g == 1) ? iphs_b_mag : iphs_c_mag;
			assign ovi_hit[g] = phase_overcurrent_enable &&
				(mag > iphs_limit_reg);
		end
	endgenerate
	assign ovi_hit[3] = link_overcurrent_enable &&
		(ibus_mag > ibus_limit_reg);

	// A hit in the clear cycle survives: set wins over clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovi_flags <= 4'h0;
		end else begin
			ovi_flags <= ovi_hit |
				(ctrl_reg[fms_pkg::CTRL_OVI_CLEAR] ? 4'h0 : ovi_flags);
		end
	end

	// ------------------------------------------------------------
	// Control mode and rotor angle selection
	// ------------------------------------------------------------
	always_comb begin
		case (rot_sel_reg)
			fms_pkg::ROT_ENCODER:  rot_next = angles_in.encoder;
			fms_pkg::ROT_HALL:     rot_next = angles_in.hall;
			fms_pkg::ROT_RESOLV0:  rot_next = angles_in.resolv0;
			fms_pkg::ROT_RESOLV1:  rot_next = angles_in.resolv1;
			fms_pkg::ROT_OBSERVER: rot_next = angles_in.observer;
			fms_pkg::ROT_MANROT:   rot_next = angles_in.manrot;
			fms_pkg::ROT_EXT0:     rot_next = angles_in.ext0;
			fms_pkg::ROT_EXT1:     rot_next = angles_in.ext1;
			default:               rot_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_mode <= fms_pkg::MODE_TORQUE;
			rot_angle <= 32'h0000_0000;
			fbk_angle <= 32'h0000_0000;
		end else begin
			ctrl_mode <= mode_dec(ctrl_reg[fms_pkg::CTRL_SPEED_TO_TORQUE],
				ctrl_reg[fms_pkg::CTRL_MANROT_TO_SPEED]);
			rot_angle <= rot_next;
			fbk_angle <= ctrl_reg[fms_pkg::CTRL_FBK_ANGDEF] ?
				rot_next : preset_angle;
		end
	end

	// ------------------------------------------------------------
	// Cycle time: clocks between successive cycle strobes
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ts_cnt_reg <= 12'h000;
			tsclocks   <= 12'h000;
		end else if (cycle_sync) begin
			// A stalled cycle reads full scale, never a small wrapped value
			tsclocks   <= (ts_cnt_reg == 12'hfff) ? 12'hfff :
				ts_cnt_reg + 12'h001;
			ts_cnt_reg <= 12'h000;
		end else if (ts_cnt_reg != 12'hfff) begin
			// Saturate rather than wrap on a stalled cycle
			ts_cnt_reg <= ts_cnt_reg + 12'h001;
		end
	end

	// ------------------------------------------------------------
	// Observer controls, speed flags and position
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			obs_reset        <= 1'b1;
			obs_use_measured <= 1'b0;
			spd_fwdir        <= 1'b0;
			spd_moving       <= 1'b0;
			pos_position     <= 32'h0000_0000;
		end else begin
			obs_reset        <= ctrl_reg[fms_pkg::CTRL_OBS_RESET];
			obs_use_measured <= ctrl_reg[fms_pkg::CTRL_OBS_VSACT];
			spd_fwdir        <= eval_fwdir;
			spd_moving       <= eval_moving;
			pos_position     <= position_in;
		end
	end

	// ------------------------------------------------------------
	// Read port: data in the cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				fms_pkg::ADDR_CTRL:    reg_rdata <= {24'h000000, ctrl_reg};
				fms_pkg::ADDR_ROT_SEL: reg_rdata <= {28'h0000000, rot_sel_reg};
				fms_pkg::ADDR_ISMAX:   reg_rdata <= {15'h0000, ismax_reg};
				fms_pkg::ADDR_STATUS:  reg_rdata <= {21'h000000, ctrl_mode,
					spd_moving, spd_fwdir, ovi_flags, ismodover, modtype_ack};
				fms_pkg::ADDR_TSCLK:   reg_rdata <= {20'h00000, tsclocks};
				fms_pkg::ADDR_OVI_LIMIT: reg_rdata <= {15'h0000, iphs_limit_reg};
				// Build options readable
				fms_pkg::ADDR_CONFIG:  reg_rdata <= {
					input_channel_invert_map, input_channel_enable_map,
					manrot_option_param, angle_table_size_param,
					exciter_polarity_param, transform_input_phase_count};
				default:               reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

/* fms_top_chk.sv */
// Port-level assertions for the mode select and supervision block
`timescale 1ns/10ps
module fms_top_chk #(
	parameter logic [3:0] overcurrent_consecutive_limit = fms_pkg::OVF_CLIM_DEF
) (
	input wire logic                  core_clk,
	input wire logic                  rst_b,
	input wire logic [7:0]            reg_addr,
	input wire logic [31:0]           reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [31:0]           reg_rdata,
	input wire logic                  cycle_sync,
	input wire logic [16:0]           is_modulus,
	input wire fms_pkg::fms_coil_type coil_in,
	input wire logic [5:0]            coil_drive,
	input wire logic                  modtype_ack,
	input wire logic                  ismodover,
	input wire logic [3:0]            ovi_flags,
	input wire logic [2:0]            ctrl_mode,
	input wire logic [11:0]           tsclocks,
	input wire logic                  obs_reset,
	input wire logic                  obs_use_measured
);
	logic [7:0]  ctrl_sh;
	logic [16:0] ref_sh;
	logic [2:0]  clr_age;
	logic [3:0]  bad_cnt;
	logic [11:0] gap_cnt;
	logic        seen_sync;
	logic        ctrl_wr;
	// Host settings are only visible through the write port, so shadow them
	assign ctrl_wr = reg_wr && (reg_addr == fms_pkg::ADDR_CTRL);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_sh <= 8'h00;
			ref_sh  <= 17'h1ffff;
			clr_age <= 3'h0;
		end else begin
			if (ctrl_wr) ctrl_sh <= reg_wdata[7:0];
			if (reg_wr && reg_addr == fms_pkg::ADDR_ISMAX) ref_sh <= reg_wdata[16:0];
			clr_age <= {clr_age[1:0], ctrl_wr && reg_wdata[7]};
		end
	end
	// Bad-cycle run length and clocks since the last control cycle mark
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bad_cnt   <= 4'h0;
			gap_cnt   <= 12'h000;
			seen_sync <= 1'b0;
		end else if (cycle_sync) begin
			bad_cnt   <= (is_modulus > ref_sh) ?
				bad_cnt + 4'(bad_cnt != 4'hf) : 4'h0;
			gap_cnt   <= 12'h000;
			seen_sync <= 1'b1;
		end else if (gap_cnt != 12'hfff) begin
			gap_cnt <= gap_cnt + 12'h001;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_ack_pair: assert property (
		modtype_ack == ($past(ctrl_sh[0]) && $past(ctrl_sh[1])))
		else $error("ack disagrees with request and motor type");
	chk_coil_route: assert property (1'b1 |=>
		coil_drive == (modtype_ack ? $past(coil_in.pfm) : $past(coil_in.pwm)))
		else $error("coil drive not from the acknowledged modulator");
	chk_ovf_run: assert property (
		ismodover == (bad_cnt >= overcurrent_consecutive_limit))
		else $error("overflow flag disagrees with bad-cycle run");
	chk_mode_pick: assert property ($past(rst_b) |-> ctrl_mode ==
		(!$past(ctrl_sh[2]) ? 3'b001 : $past(ctrl_sh[3]) ? 3'b100 : 3'b010))
		else $error("control mode disagrees with selectors");
	chk_obs_hold: assert property (
		$past(rst_b) |-> obs_reset == $past(ctrl_sh[5]))
		else $error("observer reset disagrees with command");
	chk_vs_source: assert property (
		$past(rst_b) |-> obs_use_measured == $past(ctrl_sh[6]))
		else $error("observer voltage source disagrees with selector");
	chk_tsclk_span: assert property (
		cycle_sync && seen_sync |=> tsclocks ==
		(($past(gap_cnt) == 12'hfff) ? 12'hfff : $past(gap_cnt) + 12'h001))
		else $error("cycle clock count wrong");
	chk_ovi_release: assert property (
		$fell(ovi_flags[0]) || $fell(ovi_flags[3]) |-> |clr_age)
		else $error("overcurrent flag dropped without clear");
	chk_rdata_quiet: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule
bind fms_top fms_top_chk #(
	.overcurrent_consecutive_limit(overcurrent_consecutive_limit)
) chk_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .cycle_sync(cycle_sync), .is_modulus(is_modulus),
	.coil_in(coil_in), .coil_drive(coil_drive), .modtype_ack(modtype_ack),
	.ismodover(ismodover), .ovi_flags(ovi_flags), .ctrl_mode(ctrl_mode),
	.tsclocks(tsclocks), .obs_reset(obs_reset),
	.obs_use_measured(obs_use_measured));

/* fms_stage_model.sv */
// Stand-in for the modulators, angle sources and control cycle pacing
`timescale 1ns/10ps
module fms_stage_model #(
	parameter int SYNC_PERIOD = 20
) (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	output logic                    cycle_sync,
	output fms_pkg::fms_coil_type   coil_in,
	output fms_pkg::fms_angles_type angles_in
);
	logic [11:0] tick_reg;
	logic        wrap;
	// One mark per control cycle; coil pattern moves every clock so a stale
	// or swapped route cannot hide
	assign wrap = (tick_reg == 12'(SYNC_PERIOD - 1));
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_reg   <= 12'h000;
			cycle_sync <= 1'b0;
			coil_in    <= '0;
		end else begin
			tick_reg   <= wrap ? 12'h000 : tick_reg + 12'h001;
			cycle_sync <= wrap;
			coil_in    <= {tick_reg[5:0], ~tick_reg[5:0]};
		end
	end
	// Distinct angle per source so a wrong pick shows
	assign angles_in = {32'h1111_0001, 32'h2222_0002, 32'h3333_0003,
		32'h4444_0004, 32'h5555_0005, 32'h6666_0006, 32'h7777_0007,
		32'h8888_0008};
endmodule

/* fms_top_tb.sv */
// Self-checking bench for the mode select and supervision block
`timescale 1ns/10ps
module fms_top_tb;
	localparam int PER = 20;
	logic                    core_clk, rst_b, reg_wr, reg_rd, cycle_sync;
	logic [7:0]              reg_addr;
	logic [31:0]             reg_wdata, reg_rdata, rd_word, preset_angle;
	logic [16:0]             is_modulus, iphs_a_mag, iphs_b_mag;
	logic [16:0]             iphs_c_mag, ibus_mag;
	fms_pkg::fms_coil_type   coil_in;
	fms_pkg::fms_coil_type   coil_prev;
	fms_pkg::fms_angles_type angles_in;
	logic                    eval_fwdir, eval_moving, modtype_ack, ismodover;
	logic [31:0]             position_in, rot_angle, fbk_angle, pos_position;
	logic [5:0]              coil_drive;
	logic [3:0]              ovi_flags;
	logic [2:0]              ctrl_mode;
	logic [11:0]             tsclocks;
	logic                    spd_fwdir, spd_moving, obs_reset, obs_use_measured;
	int                      mismatches, check_count;
	// Two consecutive bad cycles needed, so a one-cycle slip shows
	fms_top #(.overcurrent_consecutive_limit(4'h2)) dut_u (
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cycle_sync(cycle_sync), .is_modulus(is_modulus),
		.iphs_a_mag(iphs_a_mag), .iphs_b_mag(iphs_b_mag),
		.iphs_c_mag(iphs_c_mag), .ibus_mag(ibus_mag), .coil_in(coil_in),
		.angles_in(angles_in), .preset_angle(preset_angle),
		.eval_fwdir(eval_fwdir), .eval_moving(eval_moving),
		.position_in(position_in), .coil_drive(coil_drive),
		.modtype_ack(modtype_ack), .ismodover(ismodover),
		.ovi_flags(ovi_flags), .ctrl_mode(ctrl_mode), .rot_angle(rot_angle),
		.fbk_angle(fbk_angle), .tsclocks(tsclocks), .spd_fwdir(spd_fwdir),
		.spd_moving(spd_moving), .obs_reset(obs_reset),
		.obs_use_measured(obs_use_measured), .pos_position(pos_position));
	fms_stage_model #(.SYNC_PERIOD(PER)) stage_u (.core_clk(core_clk),
		.rst_b(rst_b), .cycle_sync(cycle_sync), .coil_in(coil_in),
		.angles_in(angles_in));
	// ------------------------------------------------------------
	// Bus cycles and comparison
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 rd_word = reg_rdata;
	endtask
	// Outputs are levels one edge behind the settings; three edges is slack
	// The coil pattern moves every clock, so keep the one the last edge took
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1 coil_prev = coil_in;
		@(posedge core_clk);
		#1;
	endtask
	task automatic wsync();
		repeat (4 * PER) begin
			@(posedge core_clk);
			if (cycle_sync === 1'b1) break;
		end
		#1;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("obs_reset in reset", obs_reset, 1'b1);
		chk("ismodover in reset", ismodover, 1'b0);
		@(posedge core_clk);
		rst_b <= 1'b1;
		rd(8'h18);
		chk("config", rd_word, 32'h00008383);
		rd(8'h1c);
		chk("unmapped", rd_word, 32'h0);
	endtask
	task automatic t_sel();
		logic [31:0] exp_ang;
		for (int k = 0; k < 4; k++) begin
			wr(8'h00, 32'(k));
			settle();
			chk("modtype_ack", modtype_ack, k == 3);
			chk("coil_drive", coil_drive,
				(k == 3) ? coil_prev.pfm : coil_prev.pwm);
			wr(8'h00, 32'(k) << 2);
			settle();
			chk("ctrl_mode", ctrl_mode, (k % 2 == 0) ? 3'b001 :
				(k > 1) ? 3'b100 : 3'b010);
		end
		wr(8'h00, 32'h10);
		for (int k = 0; k < 9; k++) begin
			wr(8'h04, 32'(k));
			settle();
			// Codes past the last source select nothing and read zero
			exp_ang = (k < 8) ? angles_in[255 - 32 * (k % 8) -: 32] : 32'h0;
			chk("rot_angle", rot_angle, exp_ang);
			chk("fbk mux", fbk_angle, exp_ang);
		end
		wr(8'h00, 32'h0);
		settle();
		chk("fbk preset", fbk_angle, 32'h5a5a_0f0f);
	endtask
	task automatic t_status();
		@(posedge core_clk);
		eval_fwdir  <= 1'b1;
		position_in <= 32'h0001_8000;
		wr(8'h00, 32'h64);
		settle();
		chk("obs_reset", obs_reset, 1'b1);
		chk("obs_use_measured", obs_use_measured, 1'b1);
		chk("fwdir moving", {spd_fwdir, spd_moving}, 2'b10);
		chk("position", pos_position, 32'h0001_8000);
		rd(8'h0c);
		chk("status mode dir", rd_word[10:6], 5'b01001);
		@(posedge core_clk);
		eval_fwdir  <= 1'b0;
		eval_moving <= 1'b1;
		wr(8'h00, 32'h0);
		settle();
		chk("obs released", {obs_reset, obs_use_measured}, 2'b00);
		chk("reverse moving", {spd_fwdir, spd_moving}, 2'b01);
	endtask
	task automatic t_ovf();
		wr(8'h08, 32'h100);
		for (int k = 0; k < 5; k++) begin
			@(posedge core_clk);
			is_modulus <= (k == 2) ? 17'h00050 : 17'h00200;
			wsync();
			chk("ismodover", ismodover, k == 1 || k == 4);
		end
		rd(8'h0c);
		chk("status overflow", rd_word[1], 1'b1);
		wsync();
		chk("tsclocks", tsclocks, 12'(PER));
	endtask
	task automatic t_ovi();
		wr(8'h14, 32'h400);
		wr(8'h18, 32'h400);
		@(posedge core_clk);
		iphs_a_mag <= 17'h00500;
		iphs_c_mag <= 17'h00500;
		ibus_mag   <= 17'h00500;
		@(posedge core_clk);
		iphs_a_mag <= 17'h00010;
		iphs_c_mag <= 17'h00010;
		ibus_mag   <= 17'h00010;
		settle();
		chk("ovi held", ovi_flags, 4'b1101);
		rd(8'h0c);
		chk("status ovi", rd_word[5:2], 4'b1101);
		wr(8'h00, 32'h80);
		settle();
		chk("ovi cleared", ovi_flags, 4'h0);
		// Phase B stays over its limit through a clear: the set must win
		@(posedge core_clk);
		iphs_b_mag <= 17'h00500;
		wr(8'h00, 32'h80);
		settle();
		chk("ovi set wins", ovi_flags, 4'b0010);
		@(posedge core_clk);
		iphs_b_mag <= 17'h00010;
		wr(8'h00, 32'h80);
		settle();
		chk("ovi b cleared", ovi_flags, 4'h0);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Cuts a hang short well past the expected few hundred cycles
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
	// Main sequence
	initial begin
		{rst_b, reg_wr, reg_rd, eval_fwdir, eval_moving} = 5'h0;
		reg_addr     = 8'h00;
		reg_wdata    = 32'h0;
		is_modulus   = 17'h0;
		iphs_a_mag   = 17'h00010;
		iphs_b_mag   = 17'h00010;
		iphs_c_mag   = 17'h00010;
		ibus_mag     = 17'h00010;
		preset_angle = 32'h5a5a_0f0f;
		position_in  = 32'h0;
		mismatches   = 0;
		check_count  = 0;
		repeat (6) @(posedge core_clk);
		#1;
		t_reset();
		t_sel();
		t_status();
		t_ovf();
		t_ovi();
		complete_run();
	end
endmodule
